// File: hw/tiec_map.svh
// Register map, field positions, reset values and counts of the interval/event/capture timer
// Functional notes
// - Interval match clears counter, keeps counting, raises match
// - Count clock chosen by prescale bits 0 and 1
// - Clock codes: clk, clk/4, clk/256, edge A
// - Interval overflow when compare is FFFF, or on the wrap when compare is below count
// - Interval period is (compare plus one) count clocks
// - Compare below count: run to wrap first
// - Event mode counts valid edges on input A
// - Event count match clears counter, raises match
// - Input A edge chosen by bits 4, 5
// - Edge codes: fall, rise, prohibited, both
// - Event input sampled at clock, seen twice
// - Event counting begins after edge seen twice
// - Capture inputs sampled at count clock, twice
// - Input A edge captures counter into B
// - Input B edge captures into A, raises match
// - Overflow flag held until software clears it
`ifndef TIEC_MAP_SVH
`define TIEC_MAP_SVH

// Byte offsets on the bus
`define TIEC_OFS_MODE 8'h00
`define TIEC_OFS_CTRL 8'h04
`define TIEC_OFS_PRESCALE 8'h08
`define TIEC_OFS_CMP_CAP_A 8'h0C
`define TIEC_OFS_CAP_B 8'h10
`define TIEC_OFS_COUNTER 8'h14
`define TIEC_OFS_STATUS 8'h18

// Mode register codes
`define TIEC_MODE_STOP 2'h0
`define TIEC_MODE_FREE 2'h1
`define TIEC_MODE_CLEAR 2'h2

// Control register: compare/capture A acts as capture
`define TIEC_CTRL_CAP_A_BIT 0

// Prescale/edge-select fields
`define TIEC_CLK_SEL_LO 0
`define TIEC_CLK_SEL_HI 1
`define TIEC_EDGE_A_LO 4
`define TIEC_EDGE_A_HI 5
`define TIEC_EDGE_B_LO 6
`define TIEC_EDGE_B_HI 7

// Count clock codes
`define TIEC_CLK_FULL 2'h0
`define TIEC_CLK_DIV4 2'h1
`define TIEC_CLK_DIV256 2'h2
`define TIEC_CLK_EDGE_A 2'h3

// Edge select codes
`define TIEC_EDGE_FALL 2'h0
`define TIEC_EDGE_RISE 2'h1
`define TIEC_EDGE_BOTH 2'h3

// Status register: overflow flag, write one to clear
`define TIEC_STAT_OVF_BIT 0

// Prescaler: low two bits all ones every 4, all eight every 256
`define TIEC_DIV4_MASK 8'h03
`define TIEC_DIV256_MASK 8'hFF

// Reset values
`define TIEC_RST_8 8'h00
`define TIEC_RST_16 16'h0000
`define TIEC_RST_32 32'h0000_0000
`define TIEC_CNT_MAX 16'hFFFF
`define TIEC_CNT_ONE 16'h0001

`endif

// File: hw/tiec_pkg.sv
// Types shared by the timer files
package tiec_pkg;
  typedef enum logic [1:0] {TIEC_STOPPED, TIEC_FREE_RUN, TIEC_CLEAR_MATCH} tiec_mode_e;
  typedef logic [15:0] tiec_word_t;
  typedef logic [1:0] tiec_sel_t;
endpackage

// File: hw/tiec_edge_filter.sv
// Pin synchroniser, twice-seen level filter and valid-edge detector
`timescale 1ns/10ps
`include "tiec_map.svh"
module tiec_edge_filter
  import tiec_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic sample_en_i,
  input wire tiec_pkg::tiec_sel_t edge_sel_i,
  // Pin and result
  input wire logic pin_i,
  output logic edge_o
);
  import tiec_pkg::*;

  logic sync_a;
  logic sync_b;
  logic samp_a;
  logic samp_b;
  logic level;
  logic next_samp_a;
  logic next_samp_b;
  logic next_level;
  logic next_edge;

  always_comb
  begin
    next_samp_a = samp_a;
    next_samp_b = samp_b;
    next_level = level;
    next_edge = 1'b0;
    if (!enable_i)
    begin
      // Level forced low while stopped, so a high pin at start reads as rising
      next_samp_a = 1'b0;
      next_samp_b = 1'b0;
      next_level = 1'b0;
    end
    else if (sample_en_i)
    begin
      next_samp_a = sync_b;
      next_samp_b = samp_a;
      if (samp_a == samp_b && samp_a != level)
      begin
        next_level = samp_a;
        unique case (edge_sel_i)
          `TIEC_EDGE_FALL: next_edge = !samp_a;
          `TIEC_EDGE_RISE: next_edge = samp_a;
          `TIEC_EDGE_BOTH: next_edge = 1'b1;
          default: next_edge = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      samp_a <= 1'b0;
      samp_b <= 1'b0;
      level <= 1'b0;
      edge_o <= 1'b0;
    end
    else
    begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      samp_a <= next_samp_a;
      samp_b <= next_samp_b;
      level <= next_level;
      edge_o <= next_edge;
    end
  end
endmodule

// File: hw/tiec_timer.sv
// 16-bit interval timer, event counter and pulse-width capture with Wishbone slave
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`include "tiec_map.svh"
module tiec_timer
  import tiec_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Edge pins
  input wire logic edge_input_a_i,
  input wire logic edge_input_b_i,
  // Events
  output logic match_irq_o,
  output logic capture_irq_o,
  output logic overflow_flag_o
);
  import tiec_pkg::*;

  function automatic tiec_word_t merge16(input tiec_word_t old, input logic [31:0] dat,
                                         input logic [3:0] sel);
    tiec_word_t res;
    res = old;
    if (sel[0])
    begin
      res[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    return sel[0] ? dat[7:0] : old;
  endfunction

  function automatic tiec_mode_e decode_mode(input logic [7:0] code);
    tiec_mode_e m;
    case (code[1:0])
      `TIEC_MODE_FREE: m = TIEC_FREE_RUN;
      `TIEC_MODE_CLEAR: m = TIEC_CLEAR_MATCH;
      default: m = TIEC_STOPPED;
    endcase
    return m;
  endfunction

  // Software-visible state
  logic [7:0] timer_mode_ctrl_reg;
  logic [7:0] capture_compare_ctrl_reg;
  logic [7:0] prescale_edge_select_reg;
  tiec_word_t compare_capture_a;
  tiec_word_t capture_b;
  tiec_word_t main_counter;
  logic overflow_flag;

  // Next values
  logic [7:0] next_mode_reg;
  logic [7:0] next_ctrl_reg;
  logic [7:0] next_prescale_reg;
  tiec_word_t next_cmp_cap_a;
  tiec_word_t next_capture_b;
  tiec_word_t next_counter;
  logic next_overflow;
  logic next_match_irq;
  logic next_capture_irq;
  logic next_ack;
  logic [31:0] next_dat;
  logic [7:0] prescaler;
  logic [7:0] next_prescaler;

  // Decoded control
  tiec_mode_e mode;
  tiec_sel_t clock_sel;
  tiec_sel_t edge_a_sel;
  tiec_sel_t edge_b_sel;
  logic running;
  logic cap_a_mode;
  logic tick_div4;
  logic tick_div256;
  logic count_tick;
  logic count_en;
  logic filt_sample;
  logic edge_a;
  logic edge_b;
  logic bus_write;
  logic at_match;
  logic at_top;
  logic counting;
  logic clear_ovf;
  logic write_cmp;

  assign mode = decode_mode(timer_mode_ctrl_reg);
  assign running = (mode != TIEC_STOPPED);
  assign cap_a_mode = capture_compare_ctrl_reg[`TIEC_CTRL_CAP_A_BIT];
  assign clock_sel = prescale_edge_select_reg[`TIEC_CLK_SEL_HI:`TIEC_CLK_SEL_LO];
  assign edge_a_sel = prescale_edge_select_reg[`TIEC_EDGE_A_HI:`TIEC_EDGE_A_LO];
  assign edge_b_sel = prescale_edge_select_reg[`TIEC_EDGE_B_HI:`TIEC_EDGE_B_LO];
  assign bus_write = cyc_i && stb_i && we_i && ack_o;
  assign counting = running && count_en;
  assign at_top = (main_counter == `TIEC_CNT_MAX);
  // Write one to clear, only through the low byte lane
  assign clear_ovf = bus_write && (adr_i == `TIEC_OFS_STATUS) && sel_i[0] &&
                     dat_i[`TIEC_STAT_OVF_BIT];
  assign write_cmp = bus_write && (adr_i == `TIEC_OFS_CMP_CAP_A);

  // Prescaler runs freely so the divided ticks have a fixed phase
  assign tick_div4 = ((prescaler & `TIEC_DIV4_MASK) == `TIEC_DIV4_MASK);
  assign tick_div256 = (prescaler == `TIEC_DIV256_MASK);

  always_comb
  begin
    next_prescaler = prescaler + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prescaler <= `TIEC_RST_8;
    end
    else
    begin
      prescaler <= next_prescaler;
    end
  end

  // Count clock selection
  always_comb
  begin
    unique case (clock_sel)
      `TIEC_CLK_FULL: count_tick = 1'b1;
      `TIEC_CLK_DIV4: count_tick = tick_div4;
      `TIEC_CLK_DIV256: count_tick = tick_div256;
      `TIEC_CLK_EDGE_A: count_tick = 1'b0;
    endcase
  end

  // Event counting filters at the full clock, capture at the count clock
  assign filt_sample = (clock_sel == `TIEC_CLK_EDGE_A) ? 1'b1 : count_tick;
  assign count_en = (clock_sel == `TIEC_CLK_EDGE_A) ? edge_a : count_tick;

  tiec_edge_filter u_filter_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(running),
    .sample_en_i(filt_sample),
    .edge_sel_i(edge_a_sel),
    .pin_i(edge_input_a_i),
    .edge_o(edge_a)
  );

  tiec_edge_filter u_filter_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(running),
    .sample_en_i(filt_sample),
    .edge_sel_i(edge_b_sel),
    .pin_i(edge_input_b_i),
    .edge_o(edge_b)
  );

  assign at_match = (mode == TIEC_CLEAR_MATCH) && !cap_a_mode &&
                    (main_counter == compare_capture_a);

  // Configuration registers
  always_comb
  begin
    next_mode_reg = timer_mode_ctrl_reg;
    next_ctrl_reg = capture_compare_ctrl_reg;
    next_prescale_reg = prescale_edge_select_reg;
    if (bus_write)
    begin
      unique case (adr_i)
        `TIEC_OFS_MODE: next_mode_reg = merge8(timer_mode_ctrl_reg, dat_i, sel_i);
        `TIEC_OFS_CTRL: next_ctrl_reg = merge8(capture_compare_ctrl_reg, dat_i, sel_i);
        `TIEC_OFS_PRESCALE: next_prescale_reg = merge8(prescale_edge_select_reg, dat_i, sel_i);
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_mode_ctrl_reg <= `TIEC_RST_8;
      capture_compare_ctrl_reg <= `TIEC_RST_8;
      prescale_edge_select_reg <= `TIEC_RST_8;
    end
    else
    begin
      timer_mode_ctrl_reg <= next_mode_reg;
      capture_compare_ctrl_reg <= next_ctrl_reg;
      prescale_edge_select_reg <= next_prescale_reg;
    end
  end

  // Counter and overflow flag
  always_comb
  begin
    next_counter = main_counter;
    next_overflow = overflow_flag;
    // Software clear first, so a same-cycle hardware set below wins
    if (clear_ovf)
    begin
      next_overflow = 1'b0;
    end
    if (!running)
    begin
      next_counter = `TIEC_RST_16;
    end
    else if (count_en)
    begin
      // Leaving the top value sets the flag, by a match at FFFF or by the wrap
      if (at_top)
      begin
        next_overflow = 1'b1;
      end
      if (at_match)
      begin
        next_counter = `TIEC_RST_16;
      end
      else
      begin
        // Compare below count: no match until after the wrap
        next_counter = main_counter + `TIEC_CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      main_counter <= `TIEC_RST_16;
      overflow_flag <= 1'b0;
    end
    else
    begin
      main_counter <= next_counter;
      overflow_flag <= next_overflow;
    end
  end

  // Captures and event pulses
  always_comb
  begin
    next_cmp_cap_a = compare_capture_a;
    next_capture_b = capture_b;
    next_match_irq = 1'b0;
    next_capture_irq = 1'b0;
    if (write_cmp)
    begin
      next_cmp_cap_a = merge16(compare_capture_a, dat_i, sel_i);
    end
    if (counting && at_match)
    begin
      next_match_irq = 1'b1;
    end
    // Capture is not possible while input A is the count clock
    if (running && clock_sel != `TIEC_CLK_EDGE_A)
    begin
      if (edge_a)
      begin
        next_capture_b = main_counter;
        next_capture_irq = 1'b1;
      end
      // Capture wins over a software write in the same cycle
      if (edge_b && cap_a_mode)
      begin
        next_cmp_cap_a = main_counter;
        next_match_irq = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      compare_capture_a <= `TIEC_RST_16;
      capture_b <= `TIEC_RST_16;
      match_irq_o <= 1'b0;
      capture_irq_o <= 1'b0;
    end
    else
    begin
      compare_capture_a <= next_cmp_cap_a;
      capture_b <= next_capture_b;
      match_irq_o <= next_match_irq;
      capture_irq_o <= next_capture_irq;
    end
  end

  assign overflow_flag_o = overflow_flag;

  // Bus answer: one wait state, read data registered with ack
  always_comb
  begin
    next_ack = cyc_i && stb_i && !ack_o;
    next_dat = `TIEC_RST_32;
    if (cyc_i && stb_i && !we_i && !ack_o)
    begin
      unique case (adr_i)
        `TIEC_OFS_MODE: next_dat = {24'h00_0000, timer_mode_ctrl_reg};
        `TIEC_OFS_CTRL: next_dat = {24'h00_0000, capture_compare_ctrl_reg};
        `TIEC_OFS_PRESCALE: next_dat = {24'h00_0000, prescale_edge_select_reg};
        `TIEC_OFS_CMP_CAP_A: next_dat = {16'h0000, compare_capture_a};
        `TIEC_OFS_CAP_B: next_dat = {16'h0000, capture_b};
        `TIEC_OFS_COUNTER: next_dat = {16'h0000, main_counter};
        `TIEC_OFS_STATUS: next_dat = {31'h0000_0000, overflow_flag};
        default: next_dat = `TIEC_RST_32;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= `TIEC_RST_32;
    end
    else
    begin
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end
endmodule

// File: sim/tiec_timer_chk.sv
// Bus handshake and event pulse checks bound to the timer top
`timescale 1ns/10ps
module tiec_timer_chk
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pins and events
  input wire logic edge_input_a_i,
  input wire logic edge_input_b_i,
  input wire logic match_irq_o,
  input wire logic capture_irq_o,
  input wire logic overflow_flag_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic ovf_clr;
  // A clear strobe is the only way the flag may drop
  assign ovf_clr = ack_o && stb_i && we_i && adr_i == 8'h18 && sel_i[0] && dat_i[0];
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_unmapped_zero: assert property (ack_o && $past(adr_i) == 8'h1C |-> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_match_pulse: assert property (match_irq_o |=> !match_irq_o)
    else $error("match pulse too long");
  a_cap_pulse: assert property (capture_irq_o |=> !capture_irq_o)
    else $error("capture pulse too long");
  a_ovf_hold: assert property (overflow_flag_o && !ovf_clr |=> overflow_flag_o)
    else $error("overflow dropped without clear");
  c_match: cover property (match_irq_o);
  c_capture: cover property (capture_irq_o);
  c_ovf: cover property ($rose(overflow_flag_o));
endmodule

bind tiec_timer tiec_timer_chk chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .edge_input_a_i(edge_input_a_i),
  .edge_input_b_i(edge_input_b_i), .match_irq_o(match_irq_o),
  .capture_irq_o(capture_irq_o), .overflow_flag_o(overflow_flag_o));

// File: sim/tiec_pulse_src.sv
// External pulse source driving one timer edge pin
`timescale 1ns/10ps
module tiec_pulse_src
(
  // Clock
  input wire logic clk_i,
  // Pin
  output logic pin_o
);
  initial pin_o = 1'b0;
  // Long low tail lets the filter and counter settle
  task automatic pulse(input int w);
    @(posedge clk_i);
    pin_o <= 1'b1;
    repeat (w) @(posedge clk_i);
    pin_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// File: sim/tiec_timer_test.sv
// Self-checking bench for the interval, event and capture timer
`timescale 1ns/10ps
module tiec_timer_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o, match_irq_o, capture_irq_o, overflow_flag_o, pin_a, pin_b;
  logic [31:0] q, v;
  int mismatches = 0;
  int cmp_count = 0;
  int n_match = 0;
  int n_cap = 0;
  int t, c0, c1;
  int divs[3] = '{1, 4, 256};
  logic [7:0] pcode[4] = '{8'h03, 8'h13, 8'h33, 8'h23};
  int evs[4] = '{3, 3, 6, 0};
  tiec_timer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .edge_input_a_i(pin_a), .edge_input_b_i(pin_b),
    .match_irq_o(match_irq_o), .capture_irq_o(capture_irq_o),
    .overflow_flag_o(overflow_flag_o));
  tiec_pulse_src src_a (.clk_i(clk_i), .pin_o(pin_a));
  tiec_pulse_src src_b (.clk_i(clk_i), .pin_o(pin_b));
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (match_irq_o === 1'b1) n_match <= n_match + 1;
    if (capture_irq_o === 1'b1) n_cap <= n_cap + 1;
  end
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    if (n >= 20) mismatches++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wait_match(input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (match_irq_o !== 1'b1 && n < lim);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #(95000 * 40);
    mismatches++;
    give_verdict;
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, 8'h08, 0, q);
    chk("prescale reset", q, 0);
    wb(1, 8'h14, 5, q);
    wb(0, 8'h14, 0, q);
    chk("counter read only", q, 0);
    wb(0, 8'h1C, 0, q);
    chk("unmapped", q, 0);
    wb(1, 8'h0C, 32'h0000_ABCD, q);
    sel_i <= 4'h1;
    wb(1, 8'h0C, 32'h0000_1234, q);
    sel_i <= 4'h3;
    wb(0, 8'h0C, 0, q);
    chk("byte lane", q, 32'h0000_AB34);
    $display("test registers done");
    for (int i = 0; i < 3; i++)
    begin
      wb(1, 8'h00, 0, q);
      wb(1, 8'h04, 0, q);
      wb(1, 8'h0C, 3, q);
      wb(1, 8'h08, i, q);
      wb(1, 8'h00, 2, q);
      wait_match(3000, t);
      wait_match(3000, t);
      chk("period", t, 4 * divs[i]);
    end
    chk("no overflow", overflow_flag_o, 0);
    $display("test interval done");
    for (int i = 0; i < 4; i++)
    begin
      wb(1, 8'h00, 0, q);
      wb(1, 8'h0C, 32'h0000_0100, q);
      wb(1, 8'h08, pcode[i], q);
      wb(1, 8'h00, 2, q);
      repeat (3) src_a.pulse(4);
      // Single-cycle glitch must be filtered out
      src_a.pulse(1);
      wb(0, 8'h14, 0, q);
      chk("events", q, evs[i]);
    end
    wb(1, 8'h00, 0, q);
    wb(1, 8'h0C, 3, q);
    wb(1, 8'h08, 8'h13, q);
    wb(1, 8'h00, 2, q);
    c0 = n_match;
    repeat (4) src_a.pulse(4);
    chk("event matches", n_match - c0, 1);
    wb(0, 8'h14, 0, q);
    chk("event clear", q, 0);
    $display("test events done");
    wb(1, 8'h00, 0, q);
    wb(1, 8'h04, 1, q);
    wb(1, 8'h08, 8'h70, q);
    wb(1, 8'h00, 1, q);
    c0 = n_match;
    c1 = n_cap;
    fork
      src_a.pulse(20);
      src_b.pulse(30);
    join
    wb(0, 8'h0C, 0, q);
    wb(0, 8'h10, 0, v);
    chk("pulse width", v - q, 20);
    chk("capture irqs", n_cap - c1, 2);
    chk("b capture irqs", n_match - c0, 1);
    wb(0, 8'h18, 0, q);
    chk("capture overflow", q, 0);
    repeat (30) @(posedge clk_i);
    wb(0, 8'h10, 0, q);
    chk("capture hold", q, v);
    $display("test capture done");
    wb(1, 8'h00, 0, q);
    wb(1, 8'h04, 0, q);
    wb(1, 8'h0C, 32'h0000_FFFF, q);
    wb(1, 8'h08, 0, q);
    wb(1, 8'h00, 2, q);
    wait_match(70000, t);
    repeat (40) @(posedge clk_i);
    chk("overflow set", overflow_flag_o, 1);
    wb(0, 8'h18, 0, q);
    chk("overflow status", q, 1);
    wb(1, 8'h00, 0, q);
    wb(1, 8'h18, 1, q);
    chk("overflow clear", overflow_flag_o, 0);
    $display("test overflow done");
    give_verdict;
  end
endmodule
